//--- bench/fcs_flash_model.sv
// behavioural flash array behind the sequencer's macro port
// assumes sixteen bytes stand for the array, matching the shortened verify count
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
    input wire logic clock,
    input wire fcs_pkg::fcs_flash_t flash,
    output logic [7:0] flash_rdata
);
    logic [7:0] mem [16];
    logic prog_d;
    logic [16:0] addr_d;
    logic [7:0] idle_d;
    assign flash_rdata = flash.read ? mem[flash.addr[3:0]] : idle_d;
    // array starts erased
    initial
    begin
        foreach (mem[i]) mem[i] = fcs_pkg::ERASED_BYTE;
        prog_d = 1'b0;
        addr_d = 17'h0_0000;
        idle_d = 8'h00;
    end
    // programming only clears bits; a burst chain may hold prog high
    always @(posedge clock)
    begin
        prog_d <= flash.prog;
        addr_d <= flash.addr;
        if (flash.prog && (!prog_d || flash.addr != addr_d))
            mem[flash.addr[3:0]] <= mem[flash.addr[3:0]] & flash.wdata;
        if (flash.mass || (flash.erase && flash.addr[16:9] == 8'h00))
            foreach (mem[i]) mem[i] <= fcs_pkg::ERASED_BYTE;
        // released data lines toggle so stale values never look valid
        idle_d <= ~flash_rdata;
    end
endmodule : fcs_flash_model
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the flash command sequencer
// assumes fcs_pkg, the sequencer and the array model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [1:0] ST = fcs_pkg::OFS_STATUS;
    localparam logic [1:0] CM = fcs_pkg::OFS_COMMAND;
    logic clock, arst_n, stop_mode, sec, unsec, bkg, rd_d;
    fcs_pkg::fcs_reg_req_t reg_req;
    fcs_pkg::fcs_arr_wr_t arr_wr;
    fcs_pkg::fcs_flash_t flash;
    logic [7:0] reg_rdata, flash_rdata, d, d2;
    logic [16:0] a;
    logic [7:0] exp_q[$];
    logic [6:0] codes [6] = '{7'h20, 7'h25, 7'h40, 7'h41, 7'h7f, 7'h7f};
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;

    fcs_sequencer #(.VERIFY_WORDS(16), .SECTOR_TICKS(5), .MASS_TICKS(7)) dut_u (
        .clock(clock), .arst_n(arst_n), .ce(1'b1), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .arr_wr(arr_wr), .flash(flash), .flash_rdata(flash_rdata),
        .stop_mode(stop_mode), .secure_engaged(sec), .unsecure_origin(unsec),
        .background_debug_state(bkg));
    fcs_flash_model flash_u (.clock(clock), .flash(flash), .flash_rdata(flash_rdata));

    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim();
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen, input logic [7:0] ex);
        total_checks++;
        if (seen !== ex)
        begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, seen, ex);
        end
    endtask : chk

    // read data is checked in the cycle after the strobe; a hang ends the run
    always @(posedge clock)
    begin
        rd_d <= reg_req.rd;
        cyc <= cyc + 1;
        if (rd_d && exp_q.size() > 0)
            chk(reg_rdata, exp_q.pop_front());
        if (flash.erase)
            chk({7'h00, |flash.addr[8:0]}, 8'h00);
        if (cyc == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task automatic wreg(input logic [1:0] ad, input logic [7:0] wd);
        @(posedge clock);
        reg_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        reg_req.wr <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [1:0] ad, input logic [7:0] ex);
        exp_q.push_back(ex);
        @(posedge clock);
        reg_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        reg_req.rd <= 1'b0;
    endtask : rreg

    task automatic awr(input logic [16:0] ad, input logic [7:0] wd);
        @(posedge clock);
        arr_wr <= '{wr: 1'b1, addr: ad, data: wd};
        @(posedge clock);
        arr_wr.wr <= 1'b0;
    endtask : awr

    // first two steps only, so refusals leave no launch
    task automatic seq2(input logic [16:0] ad, input logic [7:0] wd, input logic [6:0] c);
        awr(ad, wd);
        wreg(CM, {1'b0, c});
    endtask : seq2

    task automatic run(input logic [16:0] ad, input logic [7:0] wd, input logic [6:0] c);
        seq2(ad, wd, c);
        wreg(ST, 8'h80);
    endtask : run

    initial
    begin
        arst_n = 1'b0;
        reg_req = '0;
        arr_wr = '0;
        {stop_mode, sec, unsec, bkg} = 4'h0;
        void'($urandom(32'hb2a6));
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rreg(ST, 8'hc0);
        awr(17'h0_0000, 8'h00);
        rreg(ST, 8'hd0);
        wreg(fcs_pkg::OFS_DIVIDER, 8'h00);
        rreg(fcs_pkg::OFS_DIVIDER, 8'h00);
        wreg(ST, 8'h10);
        wreg(fcs_pkg::OFS_DIVIDER, 8'h01);
        rreg(fcs_pkg::OFS_DIVIDER, 8'h81);
        a = 17'($urandom);
        run(a, 8'($urandom), fcs_pkg::CMD_ERASE_VERIFY);
        repeat (40) @(posedge clock);
        rreg(ST, 8'hc4);
        wreg(ST, 8'h04);
        rreg(ST, 8'hc4);
        // program with reads between the steps
        a = {13'h0000, 4'($urandom)};
        d = 8'($urandom) & 8'hfe;
        awr(a, d);
        rreg(ST, 8'hc4);
        wreg(CM, {1'b0, fcs_pkg::CMD_PROGRAM});
        rreg(CM, {1'b0, fcs_pkg::CMD_PROGRAM});
        wreg(ST, 8'h80);
        repeat (40) @(posedge clock);
        rreg(ST, 8'hc0);
        chk(flash_u.mem[a[3:0]], d);
        run(17'h0_0000, 8'h00, fcs_pkg::CMD_ERASE_VERIFY);
        repeat (40) @(posedge clock);
        rreg(ST, 8'hc0);
        run(17'h0_01ff, 8'h00, fcs_pkg::CMD_SECTOR_ERASE);
        repeat (40) @(posedge clock);
        run(17'h0_0000, 8'h00, fcs_pkg::CMD_ERASE_VERIFY);
        repeat (40) @(posedge clock);
        rreg(ST, 8'hc4);
        // second burst goes in while the first runs, its address ignored
        d = 8'($urandom);
        d2 = 8'($urandom);
        run(17'h0_0002, d, fcs_pkg::CMD_BURST);
        @(posedge clock);
        run(17'h0_000c, d2, fcs_pkg::CMD_BURST);
        repeat (40) @(posedge clock);
        chk(flash_u.mem[2], d);
        chk(flash_u.mem[3], d2);
        rreg(ST, 8'hc0);
        // protection hits, last entry is a bad code outside the protected range
        wreg(fcs_pkg::OFS_PROTECT, 8'h81);
        for (int i = 0; i < 6; i++)
        begin
            seq2(i == 5 ? 17'h0_0010 : 17'h0_0400, 8'h00, codes[i]);
            rreg(ST, i == 5 ? 8'hd0 : 8'he0);
            wreg(ST, 8'h30);
        end
        wreg(fcs_pkg::OFS_PROTECT, 8'h00);
        // out-of-order writes abort the sequence
        for (int i = 0; i < 5; i++)
        begin
            awr(17'h0_0001, 8'h00);
            case (i)
                0: awr(17'h0_0001, 8'h00);
                1: wreg(fcs_pkg::OFS_PROTECT, 8'h00);
                default: wreg(CM, {1'b0, fcs_pkg::CMD_PROGRAM});
            endcase
            case (i)
                2: awr(17'h0_0001, 8'h00);
                3: wreg(fcs_pkg::OFS_DIVIDER, 8'h00);
                4: wreg(ST, 8'h00);
                default: ;
            endcase
            rreg(ST, 8'hd0);
            wreg(ST, 8'h10);
        end
        chk(flash_u.mem[1], fcs_pkg::ERASED_BYTE);
        // non-burst command while an erase still runs
        run(17'h0_0000, 8'h00, fcs_pkg::CMD_MASS_ERASE);
        seq2(17'h0_0005, 8'h00, fcs_pkg::CMD_PROGRAM);
        rreg(ST, 8'h90);
        repeat (20) @(posedge clock);
        rreg(ST, 8'hd0);
        wreg(ST, 8'h10);
        // stop mode in mid-erase
        run(17'h0_0000, 8'h00, fcs_pkg::CMD_MASS_ERASE);
        @(posedge clock);
        stop_mode <= 1'b1;
        @(posedge clock);
        stop_mode <= 1'b0;
        @(posedge clock);
        chk({7'h00, flash.mass}, 8'h00);
        rreg(ST, 8'hd0);
        wreg(ST, 8'h10);
        // secured part: only mass erase from untrusted origins
        for (int i = 0; i < 2; i++)
        begin
            sec <= 1'b1;
            unsec <= (i == 0);
            bkg <= (i == 1);
            seq2(17'h0_0000, 8'h00, fcs_pkg::CMD_PROGRAM);
            rreg(ST, 8'hd0);
            wreg(ST, 8'h10);
        end
        run(17'h0_0000, 8'h00, fcs_pkg::CMD_MASS_ERASE);
        repeat (40) @(posedge clock);
        rreg(ST, 8'hc0);
        chk(flash_u.mem[2], fcs_pkg::ERASED_BYTE);
        repeat (4) @(posedge clock);
        end_sim();
    end
endmodule : testbench
`default_nettype wire

//--- hw/fcs_pkg.sv
// constants, carriers and state types of the flash command sequencer
// assumes one bus clock and an 8-bit register and array data path
package fcs_pkg;
    // register offsets on the plain register port
    localparam logic [1:0] OFS_DIVIDER = 2'h0;
    localparam logic [1:0] OFS_PROTECT = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [1:0] OFS_COMMAND = 2'h3;
    // status field positions
    localparam int ST_CBEF = 7;
    localparam int ST_CCF = 6;
    localparam int ST_PVIOL = 5;
    localparam int ST_ACCERR = 4;
    localparam int ST_BLANK = 2;
    // divider and protect fields
    localparam int DIV_LOADED_BIT = 7;
    localparam int PROT_EN_BIT = 7;
    // command codes
    localparam logic [6:0] CMD_ERASE_VERIFY = 7'h05;
    localparam logic [6:0] CMD_PROGRAM = 7'h20;
    localparam logic [6:0] CMD_BURST = 7'h25;
    localparam logic [6:0] CMD_SECTOR_ERASE = 7'h40;
    localparam logic [6:0] CMD_MASS_ERASE = 7'h41;
    // reset values
    localparam logic [6:0] RST_DIVIDER = 7'h00;
    localparam logic [7:0] RST_PROTECT = 8'h00;
    localparam logic [6:0] RST_COMMAND = 7'h00;
    // timing in timing-clock ticks, and the erased byte value
    localparam logic [14:0] PROG_TICKS = 15'h0009;
    localparam logic [14:0] BURST_TICKS = 15'h0004;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fcs_reg_req_t;

    typedef struct packed {
        logic wr;
        logic [16:0] addr;
        logic [7:0] data;
    } fcs_arr_wr_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] wdata;
        logic prog;
        logic erase;
        logic mass;
        logic read;
    } fcs_flash_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ADDR = 3'b010,
        SEQ_CMD = 3'b100
    } fcs_seq_t;

    typedef enum logic [2:0] {
        ENG_IDLE = 3'b001,
        ENG_RUN = 3'b010,
        ENG_VFY = 3'b100
    } fcs_eng_t;

    typedef struct packed {
        fcs_seq_t seq;
        fcs_eng_t eng;
        logic cbef;
        logic ccf;
        logic pviol;
        logic accerr;
        logic blank;
        logic div_loaded;
        logic [6:0] divider;
        logic [7:0] prot;
        logic [6:0] cmd;
        logic [16:0] seq_addr;
        logic [7:0] seq_data;
        logic [6:0] act_cmd;
        logic buf_full;
        logic [16:0] buf_addr;
        logic [7:0] buf_data;
        logic burst_chain;
        logic [16:0] burst_next;
        logic [6:0] pre_cnt;
        logic [14:0] tick_cnt;
        logic [16:0] vfy_idx;
        logic vfy_chk;
        logic vfy_end;
        fcs_flash_t fl;
        logic [7:0] rdata;
    } fcs_state_t;
endpackage : fcs_pkg

//--- hw/fcs_sequencer.sv
// flash command sequencer: command write sequence, engine, burst pipeline
// assumes the flash macro answers a read in the same cycle as fl.read
// Summary of operation
// RL1 - host writes array, command, then launches
// RL2 - code 05 verifies erase, ignores address data
// RL3 - verify takes one cycle per address plus few
// RL4 - blank set if all erased, stop at first
// RL5 - code 20 programs written data at address
// RL6 - protected program target sets violation, no launch
// RL7 - burst has one-entry buffer for next command
// RL8 - code 25 bursts, later addresses internally incremented
// RL9 - completion only when no burst is buffered
// RL10 - protected burst target sets violation, no launch
// RL11 - code 40 erases sector, ignores low bits
// RL12 - protected sector sets violation, else completes
// RL13 - code 41 mass erase, refused if protected
// RL14 - illegal write order sets access error, aborts
// RL15 - bad code, busy non-burst, security set error
// RL16 - writing zero to empty flag aborts sequence
// RL17 - stop mode aborts operation, purges buffer, errors
// RL18 - reads never set error flags
// RL19 - host clears access error before next sequence
// RL20 - bad code at protected address sets violation
// RL21 - host clears violation before next sequence
// RL22 - unloaded divider blocks command, sets access error
// RL23 - blank cleared on new launch, writes ignored
// RL24 - reset shows buffer empty, nothing active
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer #(
    parameter int VERIFY_WORDS = 131072,
    parameter int SECTOR_TICKS = 4000,
    parameter int MASS_TICKS = 20000
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    input wire fcs_pkg::fcs_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire fcs_pkg::fcs_arr_wr_t arr_wr,
    output fcs_pkg::fcs_flash_t flash,
    input wire logic [7:0] flash_rdata,
    input wire logic stop_mode,
    input wire logic secure_engaged,
    input wire logic unsecure_origin,
    input wire logic background_debug_state
);
    logic [1:0] rst_sync;
    logic rst_n;
    fcs_pkg::fcs_state_t q;
    fcs_pkg::fcs_state_t next_q;

    // reset released through two flops, asserted at once
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // protected when enabled and at or above the boundary sector
    function automatic logic prot_hit(input logic [7:0] prot, input logic [16:0] addr);
        prot_hit = prot[fcs_pkg::PROT_EN_BIT] && (addr[16:10] >= prot[6:0]);
    endfunction : prot_hit

    logic reg_wr_st;
    logic launch;
    logic cmd_wr;
    logic [6:0] wcode;
    logic [16:0] eff_addr;
    logic code_valid;
    assign reg_wr_st = reg_req.wr && reg_req.addr == fcs_pkg::OFS_STATUS;
    assign launch = reg_wr_st && q.seq == fcs_pkg::SEQ_CMD
        && reg_req.wdata[fcs_pkg::ST_CBEF];
    assign cmd_wr = reg_req.wr && reg_req.addr == fcs_pkg::OFS_COMMAND
        && q.seq == fcs_pkg::SEQ_ADDR;
    assign wcode = reg_req.wdata[6:0];
    // burst after the first uses the internal address
    assign eff_addr = (wcode == fcs_pkg::CMD_BURST && q.burst_chain) ? q.burst_next
        : q.seq_addr; // RL8
    assign code_valid = wcode == fcs_pkg::CMD_ERASE_VERIFY || wcode == fcs_pkg::CMD_PROGRAM
        || wcode == fcs_pkg::CMD_BURST || wcode == fcs_pkg::CMD_SECTOR_ERASE
        || wcode == fcs_pkg::CMD_MASS_ERASE;

    // whole next state: bus side first, then engine, then stop mode
    always_comb
    begin
        logic set_ae;
        logic set_pv;
        logic clr_ae;
        logic clr_pv;
        logic tick;
        logic op_done;
        set_ae = 1'b0;
        set_pv = 1'b0;
        clr_ae = 1'b0;
        clr_pv = 1'b0;
        op_done = 1'b0;
        next_q = q;
        next_q.fl.read = 1'b0;
        tick = q.pre_cnt == q.divider;
        next_q.pre_cnt = tick ? 7'h00 : q.pre_cnt + 7'h01;

        // register reads only load read data, no flag moves
        if (reg_req.rd)
        begin
            case (reg_req.addr) // RL18
                fcs_pkg::OFS_DIVIDER: next_q.rdata = {q.div_loaded, q.divider};
                fcs_pkg::OFS_PROTECT: next_q.rdata = q.prot;
                fcs_pkg::OFS_STATUS: next_q.rdata = {q.cbef, q.ccf, q.pviol, q.accerr,
                    1'b0, q.blank, 2'b00};
                default: next_q.rdata = {1'b0, q.cmd};
            endcase
        end

        // array write opens a sequence; any other is out of order
        if (arr_wr.wr)
        begin
            if (q.seq != fcs_pkg::SEQ_IDLE || !q.div_loaded)
            begin
                set_ae = 1'b1; // RL14 RL22
                next_q.seq = fcs_pkg::SEQ_IDLE;
            end
            else if (q.cbef)
            begin
                next_q.seq = fcs_pkg::SEQ_ADDR; // RL1
                next_q.seq_addr = arr_wr.addr;
                next_q.seq_data = arr_wr.data;
            end
        end

        // register writes
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                fcs_pkg::OFS_STATUS:
                begin
                    clr_pv = reg_req.wdata[fcs_pkg::ST_PVIOL];
                    clr_ae = reg_req.wdata[fcs_pkg::ST_ACCERR];
                    if (q.seq == fcs_pkg::SEQ_ADDR)
                    begin
                        set_ae = 1'b1; // RL14
                        next_q.seq = fcs_pkg::SEQ_IDLE;
                    end
                    else if (q.seq == fcs_pkg::SEQ_CMD && !launch)
                    begin
                        set_ae = 1'b1; // RL16
                        next_q.seq = fcs_pkg::SEQ_IDLE;
                    end
                end
                fcs_pkg::OFS_COMMAND:
                begin
                    if (q.seq == fcs_pkg::SEQ_CMD)
                    begin
                        set_ae = 1'b1; // RL14
                        next_q.seq = fcs_pkg::SEQ_IDLE;
                    end
                end
                default:
                begin
                    if (q.seq != fcs_pkg::SEQ_IDLE)
                    begin
                        set_ae = 1'b1; // RL14
                        next_q.seq = fcs_pkg::SEQ_IDLE;
                    end
                    else if (reg_req.addr == fcs_pkg::OFS_PROTECT)
                        next_q.prot = reg_req.wdata;
                    else if (!q.div_loaded && !q.accerr)
                    begin
                        // write-once divider
                        next_q.divider = reg_req.wdata[6:0];
                        next_q.div_loaded = 1'b1;
                    end
                end
            endcase
        end

        // command write: checks in order of precedence
        if (cmd_wr)
        begin
            next_q.cmd = wcode;
            next_q.seq = fcs_pkg::SEQ_IDLE;
            if (!code_valid)
            begin
                if (prot_hit(q.prot, q.seq_addr))
                    set_pv = 1'b1; // RL20
                else
                    set_ae = 1'b1; // RL15
            end
            else if (wcode != fcs_pkg::CMD_BURST && !q.ccf)
                set_ae = 1'b1; // RL15
            else if (secure_engaged && (unsecure_origin || background_debug_state)
                && wcode != fcs_pkg::CMD_MASS_ERASE)
                set_ae = 1'b1; // RL15
            else if (wcode == fcs_pkg::CMD_MASS_ERASE && q.prot[fcs_pkg::PROT_EN_BIT])
                set_pv = 1'b1; // RL13
            else if ((wcode == fcs_pkg::CMD_PROGRAM || wcode == fcs_pkg::CMD_BURST)
                && prot_hit(q.prot, eff_addr))
                set_pv = 1'b1; // RL6 RL10
            else if (wcode == fcs_pkg::CMD_SECTOR_ERASE && prot_hit(q.prot, q.seq_addr))
                set_pv = 1'b1; // RL12
            else
            begin
                next_q.seq = fcs_pkg::SEQ_CMD;
                next_q.seq_addr = eff_addr;
                next_q.burst_chain = wcode == fcs_pkg::CMD_BURST && q.burst_chain;
            end
        end

        // launch: start the engine, or park a burst in the buffer
        if (launch)
        begin
            next_q.seq = fcs_pkg::SEQ_IDLE;
            next_q.blank = 1'b0; // RL23
            next_q.ccf = 1'b0;
            if (q.cmd == fcs_pkg::CMD_BURST)
                next_q.burst_next = q.seq_addr + 17'h0_0001; // RL8
            if (!q.div_loaded)
                set_ae = 1'b1; // RL22
            else if (q.eng != fcs_pkg::ENG_IDLE)
            begin
                next_q.buf_full = 1'b1; // RL7
                next_q.buf_addr = q.seq_addr;
                next_q.buf_data = q.seq_data;
                next_q.cbef = 1'b0;
            end
            else
            begin
                next_q.act_cmd = q.cmd;
                next_q.tick_cnt = fcs_pkg::PROG_TICKS;
                next_q.eng = fcs_pkg::ENG_RUN;
                next_q.fl.addr = q.seq_addr;
                next_q.fl.wdata = q.seq_data;
                case (q.cmd)
                    fcs_pkg::CMD_ERASE_VERIFY:
                    begin
                        next_q.eng = fcs_pkg::ENG_VFY; // RL2
                        next_q.vfy_idx = 17'h0_0000;
                        next_q.vfy_chk = 1'b0;
                        next_q.vfy_end = 1'b0;
                    end
                    fcs_pkg::CMD_PROGRAM: next_q.fl.prog = 1'b1; // RL5
                    fcs_pkg::CMD_BURST:
                    begin
                        next_q.fl.prog = 1'b1; // RL8
                        next_q.tick_cnt = fcs_pkg::BURST_TICKS;
                        next_q.burst_chain = 1'b1;
                    end
                    fcs_pkg::CMD_SECTOR_ERASE:
                    begin
                        next_q.fl.erase = 1'b1; // RL11
                        next_q.fl.addr = {q.seq_addr[16:9], 9'h000};
                        next_q.tick_cnt = 15'(SECTOR_TICKS);
                    end
                    default:
                    begin
                        next_q.fl.mass = 1'b1; // RL13
                        next_q.tick_cnt = 15'(MASS_TICKS);
                    end
                endcase
                // a fresh non-burst command breaks the burst address chain
                if (q.cmd != fcs_pkg::CMD_BURST)
                    next_q.burst_chain = 1'b0;
            end
        end

        // engine: timed pulses, or one read per cycle for verify
        case (q.eng)
            fcs_pkg::ENG_RUN:
            begin
                if (tick)
                begin
                    next_q.tick_cnt = q.tick_cnt - 15'h0001;
                    op_done = q.tick_cnt == 15'h0001;
                end
            end
            fcs_pkg::ENG_VFY:
            begin
                if (q.vfy_chk && flash_rdata != fcs_pkg::ERASED_BYTE)
                    op_done = 1'b1; // RL4
                else if (q.vfy_end)
                begin
                    op_done = 1'b1;
                    next_q.blank = 1'b1; // RL4
                end
                else
                begin
                    next_q.fl.read = 1'b1; // RL3
                    next_q.fl.addr = q.vfy_idx;
                    next_q.vfy_chk = 1'b1;
                    next_q.vfy_end = q.vfy_idx == 17'(VERIFY_WORDS - 1);
                    next_q.vfy_idx = q.vfy_idx + 17'h0_0001;
                end
            end
            default: op_done = 1'b0;
        endcase

        // end of operation: pull a buffered burst or report completion
        if (op_done)
        begin
            next_q.fl.prog = 1'b0;
            next_q.fl.erase = 1'b0;
            next_q.fl.mass = 1'b0;
            if (next_q.buf_full)
            begin
                next_q.buf_full = 1'b0; // RL9
                next_q.cbef = 1'b1;
                next_q.fl.addr = next_q.buf_addr;
                next_q.fl.wdata = next_q.buf_data;
                next_q.fl.prog = 1'b1;
                next_q.tick_cnt = fcs_pkg::BURST_TICKS;
            end
            else
            begin
                next_q.eng = fcs_pkg::ENG_IDLE;
                next_q.ccf = 1'b1; // RL12
            end
        end

        // stop mode kills the operation and any buffered burst
        if (stop_mode && q.eng != fcs_pkg::ENG_IDLE)
        begin
            next_q.eng = fcs_pkg::ENG_IDLE; // RL17
            next_q.buf_full = 1'b0;
            next_q.cbef = 1'b1;
            next_q.ccf = 1'b1;
            next_q.fl.prog = 1'b0;
            next_q.fl.erase = 1'b0;
            next_q.fl.mass = 1'b0;
            next_q.fl.read = 1'b0;
            next_q.burst_chain = 1'b0;
            set_ae = 1'b1;
        end

        // set beats clear in the same cycle
        next_q.accerr = (q.accerr & ~clr_ae) | set_ae;
        next_q.pviol = (q.pviol & ~clr_pv) | set_pv;
        if (set_ae || set_pv)
            next_q.burst_chain = next_q.eng != fcs_pkg::ENG_IDLE && next_q.burst_chain;
    end

    // one register for all state; the clock enable freezes it
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.seq <= fcs_pkg::SEQ_IDLE;
            q.eng <= fcs_pkg::ENG_IDLE;
            q.cbef <= 1'b1; // RL24
            q.ccf <= 1'b1; // RL24
            q.divider <= fcs_pkg::RST_DIVIDER;
            q.prot <= fcs_pkg::RST_PROTECT;
            q.cmd <= fcs_pkg::RST_COMMAND;
        end
        else if (ce)
            q <= next_q;
    end

    assign reg_rdata = q.rdata;
    assign flash = q.fl;

    property p_prog_data;
        @(posedge clock) disable iff (!rst_n)
        (ce && launch && q.eng == fcs_pkg::ENG_IDLE && q.div_loaded
            && q.cmd == fcs_pkg::CMD_PROGRAM)
        |=> (flash.prog && flash.addr == $past(q.seq_addr)
            && flash.wdata == $past(q.seq_data) && !q.ccf);
    endproperty
    a_prog_data: assert property (p_prog_data) // RL5
        else $error("program did not start with written address and data");

    property p_prot_prog;
        @(posedge clock) disable iff (!rst_n)
        (ce && cmd_wr && code_valid && q.ccf && !secure_engaged
            && wcode == fcs_pkg::CMD_PROGRAM && prot_hit(q.prot, q.seq_addr))
        |=> (q.pviol && q.seq == fcs_pkg::SEQ_IDLE);
    endproperty
    a_prot_prog: assert property (p_prot_prog) // RL6
        else $error("protected program not refused");

    property p_second_addr;
        @(posedge clock) disable iff (!rst_n)
        (ce && arr_wr.wr && q.seq != fcs_pkg::SEQ_IDLE)
        |=> (q.accerr && q.seq == fcs_pkg::SEQ_IDLE);
    endproperty
    a_second_addr: assert property (p_second_addr) // RL14
        else $error("out of order array write not flagged");

    property p_no_div;
        @(posedge clock) disable iff (!rst_n)
        (ce && arr_wr.wr && !q.div_loaded)
        |=> (q.accerr && q.seq == fcs_pkg::SEQ_IDLE) ##1 (q.eng == $past(q.eng));
    endproperty
    a_no_div: assert property (p_no_div) // RL22
        else $error("array write accepted before divider load");

    property p_abort_zero;
        @(posedge clock) disable iff (!rst_n)
        (ce && reg_wr_st && q.seq == fcs_pkg::SEQ_CMD && !reg_req.wdata[fcs_pkg::ST_CBEF])
        |=> (q.accerr && q.seq == fcs_pkg::SEQ_IDLE && q.eng == $past(q.eng));
    endproperty
    a_abort_zero: assert property (p_abort_zero) // RL16
        else $error("zero to empty flag did not abort");

    property p_stop;
        @(posedge clock) disable iff (!rst_n)
        (ce && stop_mode && q.eng != fcs_pkg::ENG_IDLE)
        |=> (q.eng == fcs_pkg::ENG_IDLE && q.accerr && !q.buf_full && q.cbef
            && !flash.prog && !flash.erase && !flash.mass);
    endproperty
    a_stop: assert property (p_stop) // RL17
        else $error("stop mode did not abort operation");

    property p_buffered_no_ccf;
        @(posedge clock) disable iff (!rst_n)
        (ce && q.eng == fcs_pkg::ENG_RUN && q.buf_full && !stop_mode)
        |=> (!q.ccf && q.eng == fcs_pkg::ENG_RUN);
    endproperty
    a_buffered_no_ccf: assert property (p_buffered_no_ccf) // RL9
        else $error("completion set while burst buffered");

    property p_vfy_fail;
        @(posedge clock) disable iff (!rst_n)
        (ce && q.eng == fcs_pkg::ENG_VFY && q.vfy_chk && !stop_mode
            && flash_rdata != fcs_pkg::ERASED_BYTE)
        |=> (q.eng == fcs_pkg::ENG_IDLE && !q.blank && q.ccf);
    endproperty
    a_vfy_fail: assert property (p_vfy_fail) // RL4
        else $error("verify did not stop on non-erased byte");

    property p_blank_clear;
        @(posedge clock) disable iff (!rst_n)
        (ce && launch) |=> (!q.blank [*2]);
    endproperty
    a_blank_clear: assert property (p_blank_clear) // RL23
        else $error("blank flag not cleared on launch");

    property p_mass_prot;
        @(posedge clock) disable iff (!rst_n)
        (ce && cmd_wr && q.ccf && !secure_engaged && wcode == fcs_pkg::CMD_MASS_ERASE
            && q.prot[fcs_pkg::PROT_EN_BIT])
        |=> (q.pviol && !q.accerr == !$past(q.accerr) && q.seq == fcs_pkg::SEQ_IDLE);
    endproperty
    a_mass_prot: assert property (p_mass_prot) // RL13
        else $error("mass erase under protection not refused");
endmodule : fcs_sequencer
`default_nettype wire
